/* verilog/tdm_pkg.sv */
// Constants, register map and state types of the two-channel temperature monitor core.
// Assumes one 40 MHz clock and an external converter front end with a start/done handshake.
// Operation
// - Outside standby, converter runs continuously, each conversion started without any host request.
// - Conversions alternate local then remote; each result lands in its channel register.
// - Local result keeps only the eight most significant converter bits.
// - Remote result is 11 bits; upper eight bits sit in register 0x01.
// - Remote three low bits sit left-justified in register 0x10, other bits zero.
// - Host-written 11-bit twos-complement offset (0x11, 0x12) is added to remote results.
// - Both offset registers reset to zero, leaving remote results unmodified.
// - Each result is compared with its channel high and low limits.
// - A result outside a limit sets that limit's status flag.
// - Alert pin pulls low while any flag is set, unless alert is masked.
// - Every register is reached over the serial management bus only.
// - Host controls standby, alert mask and conversion rate.
// - Local and remote temperature registers power up at minus 128 degrees.
// - On normal power-up both channels convert before the first comparison.
// - Standby power-up compares default values, tripping both low flags and alert.
// - Standby pin high ends standby; host may read status; alert clears if values in limits.
// - One converter LSB stands for one eighth of a degree.
package tdm_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] REG_LOC_TEMP = 8'h00;
  localparam logic [7:0] REG_REM_HI = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_CONFIG = 8'h03;
  localparam logic [7:0] REG_RATE = 8'h04;
  localparam logic [7:0] REG_LOC_HLIM = 8'h05;
  localparam logic [7:0] REG_LOC_LLIM = 8'h06;
  localparam logic [7:0] REG_REM_HLIM_HI = 8'h07;
  localparam logic [7:0] REG_REM_LLIM_HI = 8'h08;
  localparam logic [7:0] REG_REM_LO = 8'h10;
  localparam logic [7:0] REG_OFS_HI = 8'h11;
  localparam logic [7:0] REG_OFS_LO = 8'h12;
  localparam logic [7:0] REG_REM_HLIM_LO = 8'h13;
  localparam logic [7:0] REG_REM_LLIM_LO = 8'h14;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values; 0x80 is the minus 128 degree code
  localparam logic [7:0] RST_TEMP = 8'h80;
  localparam logic [7:0] RST_OFS = 8'h00;
  localparam logic [7:0] RST_HLIM = 8'h7f;
  localparam logic [7:0] RST_LLIM = 8'h00;
  localparam logic [7:0] RST_LO_BITS = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h02;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int ST_BUSY = 7;
  localparam int ST_FLAG_LSB = 3;
  localparam int CFG_MASK = 7;
  localparam int CFG_STANDBY_SELECT_PIN = 6;
  localparam int RES_W = 11;
  localparam int LOC_DROP = 3;
  localparam int LSB_MILLIDEG = 125;
  localparam logic [2:0] RATE_MAX = 3'h7;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int CONV_BASE_TIME_MS = 4000;
  localparam int CONV_BASE_CYC = CONV_BASE_TIME_MS * (CLK_HZ / 1000);
  // Bus address is a core parameter default; value is arbitrary
  localparam logic [6:0] SMB_ADDR_DEF = 7'h2a;

  //////////////////////////////////////////////////////////////////////////////
  // State types
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_LOC = 2'b01,
    SEQ_REM = 2'b11,
    SEQ_CMP = 2'b10
  } tdm_seq_state_t;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0000,
    BUS_ADDR = 4'b0001,
    BUS_AACK = 4'b0011,
    BUS_PTR = 4'b0010,
    BUS_PACK = 4'b0110,
    BUS_WDAT = 4'b0111,
    BUS_WACK = 4'b0101,
    BUS_RDAT = 4'b0100,
    BUS_RACK = 4'b1100
  } tdm_bus_state_t;

endpackage : tdm_pkg

/* verilog/tdm_conv_if.sv */
// Link between the register core and the conversion sequencer.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface tdm_conv_if;
  logic [2:0] rate;
  logic standby;
  logic adc_done;
  logic adc_start;
  logic adc_remote;
  logic cmp;
  logic busy;

  modport seq (input rate, input standby, input adc_done,
               output adc_start, output adc_remote, output cmp, output busy);
  modport core (output rate, output standby, output adc_done,
                input adc_start, input adc_remote, input cmp, input busy);
endinterface : tdm_conv_if

/* verilog/tdm_conv_seq.sv */
// Free-running conversion sequencer: rate timer, local/remote alternation, compare strobe.
// Assumes the converter pulses done once per start, on the same clock.
`timescale 1ns/100ps
module tdm_conv_seq #(
  parameter int CONV_BASE_CYC = tdm_pkg::CONV_BASE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  tdm_conv_if.seq cv
);
  import tdm_pkg::*;

  typedef struct packed {
    tdm_seq_state_t st;
    logic [31:0] timer;
    logic start;
    logic remote;
    logic cmp;
    logic busy;
  } tdm_seq_st_t;

  tdm_seq_st_t s_ff;
  tdm_seq_st_t nxt_s;
  logic [31:0] period;
  logic tick;

  if (CONV_BASE_CYC < 256) begin : g_chk
    $error("CONV_BASE_CYC too small for the slowest rate shift");
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    period = 32'(CONV_BASE_CYC) >> cv.rate;
    tick = (s_ff.timer >= period - 32'h1);
    nxt_s = s_ff;
    nxt_s.start = 1'b0;
    nxt_s.cmp = 1'b0;
    nxt_s.timer = tick ? 32'h0 : s_ff.timer + 32'h1;
    case (s_ff.st)
      SEQ_IDLE: begin
        if (tick) begin
          if (cv.standby) begin
            nxt_s.cmp = 1'b1;
          end else begin
            nxt_s.start = 1'b1;
            nxt_s.busy = 1'b1;
            nxt_s.st = SEQ_LOC;
          end
        end
      end
      SEQ_LOC: begin
        if (cv.adc_done) begin
          if (cv.standby) begin
            nxt_s.st = SEQ_IDLE;
            nxt_s.busy = 1'b0;
          end else begin
            nxt_s.start = 1'b1;
            nxt_s.remote = 1'b1;
            nxt_s.st = SEQ_REM;
          end
        end
      end
      SEQ_REM: begin
        if (cv.adc_done) begin
          nxt_s.st = SEQ_CMP;
        end
      end
      SEQ_CMP: begin
        nxt_s.cmp = 1'b1;
        nxt_s.remote = 1'b0;
        nxt_s.busy = 1'b0;
        nxt_s.st = SEQ_IDLE;
      end
      default: begin
        nxt_s.st = SEQ_IDLE;
      end
    endcase
  end

  // Timer starts full so the first cycle begins right after reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_ff <= '{st: SEQ_IDLE, timer: 32'hffffffff, start: 1'b0, remote: 1'b0,
                cmp: 1'b0, busy: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign cv.adc_start = s_ff.start;
  assign cv.adc_remote = s_ff.remote;
  assign cv.cmp = s_ff.cmp;
  assign cv.busy = s_ff.busy;

  //////////////////////////////////////////////////////////////////////////////
  sequence s_idle_tick;
    s_ff.st == SEQ_IDLE && tick;
  endsequence

  sequence s_local_done;
    s_ff.st == SEQ_LOC && cv.adc_done;
  endsequence

  property p_free_run;
    @(posedge clk_i) disable iff (rst_i)
      s_idle_tick and !cv.standby |=> cv.adc_start && !cv.adc_remote;
  endproperty
  a_free_run: assert property (p_free_run) else $error("no conversion on tick");

  property p_alternate;
    @(posedge clk_i) disable iff (rst_i)
      s_local_done and !cv.standby |=> cv.adc_start && cv.adc_remote;
  endproperty
  a_alternate: assert property (p_alternate) else $error("remote not after local");

  property p_cmp_after_remote;
    @(posedge clk_i) disable iff (rst_i)
      (s_ff.st == SEQ_REM && cv.adc_done) |=> !cv.cmp ##1 cv.cmp && !cv.busy;
  endproperty
  a_cmp_after_remote: assert property (p_cmp_after_remote) else $error("late compare");

  property p_standby_select_pin_no_start;
    @(posedge clk_i) disable iff (rst_i)
      cv.standby && s_ff.st == SEQ_IDLE |=> !cv.adc_start;
  endproperty
  a_standby_select_pin_no_start: assert property (p_standby_select_pin_no_start) else $error("start in standby");

endmodule : tdm_conv_seq

/* verilog/tdm_core.sv */
// Top of the temperature monitor: bus slave, register file, limit compare, alert pin.
// Assumes bus pins already synchronous to clk_i and a converter front end on adc_* ports.
`timescale 1ns/100ps
module tdm_core #(
  parameter logic [6:0] SMB_ADDR = tdm_pkg::SMB_ADDR_DEF,
  parameter int CONV_BASE_CYC = tdm_pkg::CONV_BASE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic alert_o,
  output logic alert_oe_n_o,
  input wire logic standby_select_pin_i,
  input wire logic adc_done_i,
  input wire logic [tdm_pkg::RES_W-1:0] adc_data_i,
  output logic adc_start_o,
  output logic adc_remote_o
);
  import tdm_pkg::*;

  typedef struct packed {
    tdm_bus_state_t bst;
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic rw;
    logic drive;
    logic [7:0] ptr;
    logic [7:0] loc;
    logic [7:0] rem_hi;
    logic [7:0] rem_lo;
    logic [7:0] ofs_hi;
    logic [7:0] ofs_lo;
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] loc_hlim;
    logic [7:0] loc_llim;
    logic [7:0] rhl_hi;
    logic [7:0] rhl_lo;
    logic [7:0] rll_hi;
    logic [7:0] rll_lo;
    logic [3:0] flags;
    logic alert;
    logic pin_lo;
  } tdm_core_st_t;

  tdm_core_st_t s_ff;
  tdm_core_st_t nxt_s;
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  logic load_rd;
  logic wr_en;
  logic status_rd;
  logic [7:0] rd_byte;
  logic [RES_W-1:0] rem_sum;
  logic [RES_W-1:0] rem_val;
  logic [RES_W-1:0] loc_val;

  tdm_conv_if cv ();

  tdm_conv_seq #(
    .CONV_BASE_CYC(CONV_BASE_CYC)
  ) u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cv(cv)
  );

  if (RES_W != 11) begin : g_chk
    $error("result width must be 11");
  end

  // Signed compare; local values are widened to the remote scale
  function automatic logic below(input logic [RES_W-1:0] a, input logic [RES_W-1:0] b);
    return $signed(a) < $signed(b);
  endfunction : below

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer link; pin low means standby
  assign cv.standby = ~standby_select_pin_i | s_ff.cfg[CFG_STANDBY_SELECT_PIN];
  assign cv.rate = (s_ff.rate > {5'h0, RATE_MAX}) ? RATE_MAX : s_ff.rate[2:0];
  assign cv.adc_done = adc_done_i;

  // Offset sum wraps in 11 bits; saturation left to host calibration
  assign rem_sum = adc_data_i + {s_ff.ofs_hi, s_ff.ofs_lo[7:5]};
  assign rem_val = {s_ff.rem_hi, s_ff.rem_lo[7:5]};
  assign loc_val = {s_ff.loc, 3'h0};

  always_comb begin
    case (s_ff.ptr)
      REG_LOC_TEMP: rd_byte = s_ff.loc;
      REG_REM_HI: rd_byte = s_ff.rem_hi;
      REG_STATUS: rd_byte = {cv.busy, s_ff.flags, 3'h0};
      REG_CONFIG: rd_byte = s_ff.cfg;
      REG_RATE: rd_byte = s_ff.rate;
      REG_LOC_HLIM: rd_byte = s_ff.loc_hlim;
      REG_LOC_LLIM: rd_byte = s_ff.loc_llim;
      REG_REM_HLIM_HI: rd_byte = s_ff.rhl_hi;
      REG_REM_LLIM_HI: rd_byte = s_ff.rll_hi;
      REG_REM_LO: rd_byte = s_ff.rem_lo;
      REG_OFS_HI: rd_byte = s_ff.ofs_hi;
      REG_OFS_LO: rd_byte = s_ff.ofs_lo;
      REG_REM_HLIM_LO: rd_byte = s_ff.rhl_lo;
      REG_REM_LLIM_LO: rd_byte = s_ff.rll_lo;
      default: rd_byte = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s = s_ff;
    load_rd = 1'b0;
    wr_en = 1'b0;
    status_rd = 1'b0;
    nxt_s.scl_q = scl_i;
    nxt_s.sda_q = sda_i;
    start_c = s_ff.scl_q & scl_i & s_ff.sda_q & ~sda_i;
    stop_c = s_ff.scl_q & scl_i & ~s_ff.sda_q & sda_i;
    rise_c = scl_i & ~s_ff.scl_q;
    fall_c = ~scl_i & s_ff.scl_q;

    // Converter results, stored by the channel in flight
    if (adc_done_i) begin
      if (cv.adc_remote) begin
        nxt_s.rem_hi = rem_sum[10:3];
        nxt_s.rem_lo = {rem_sum[2:0], 5'h00};
      end else begin
        nxt_s.loc = adc_data_i[RES_W-1:LOC_DROP];
      end
    end

    // Byte-level bus slave; the pointer does not auto-increment
    if (start_c) begin
      nxt_s.bst = BUS_ADDR;
      nxt_s.cnt = 4'h0;
      nxt_s.drive = 1'b0;
    end else if (stop_c) begin
      nxt_s.bst = BUS_IDLE;
      nxt_s.drive = 1'b0;
    end else begin
      case (s_ff.bst)
        BUS_ADDR, BUS_PTR, BUS_WDAT: begin
          if (rise_c && s_ff.cnt < 4'h8) begin
            nxt_s.shift = {s_ff.shift[6:0], sda_i};
            nxt_s.cnt = s_ff.cnt + 4'h1;
          end else if (fall_c && s_ff.cnt == 4'h8) begin
            nxt_s.cnt = 4'h0;
            nxt_s.drive = 1'b1;
            if (s_ff.bst == BUS_ADDR) begin
              nxt_s.rw = s_ff.shift[0];
              nxt_s.bst = BUS_AACK;
              if (s_ff.shift[7:1] != SMB_ADDR) begin
                nxt_s.drive = 1'b0;
                nxt_s.bst = BUS_IDLE;
              end
            end else if (s_ff.bst == BUS_PTR) begin
              nxt_s.ptr = s_ff.shift;
              nxt_s.bst = BUS_PACK;
            end else begin
              wr_en = 1'b1;
              nxt_s.bst = BUS_WACK;
            end
          end
        end
        BUS_AACK: begin
          if (fall_c) begin
            nxt_s.drive = 1'b0;
            nxt_s.bst = BUS_PTR;
            load_rd = s_ff.rw;
          end
        end
        BUS_PACK, BUS_WACK: begin
          if (fall_c) begin
            nxt_s.drive = 1'b0;
            nxt_s.bst = BUS_WDAT;
          end
        end
        BUS_RDAT: begin
          if (fall_c) begin
            if (s_ff.cnt == 4'h8) begin
              nxt_s.drive = 1'b0;
              nxt_s.cnt = 4'h0;
              nxt_s.bst = BUS_RACK;
            end else begin
              nxt_s.drive = ~s_ff.shift[6];
              nxt_s.shift = {s_ff.shift[6:0], 1'b0};
              nxt_s.cnt = s_ff.cnt + 4'h1;
            end
          end
        end
        BUS_RACK: begin
          if (rise_c) begin
            if (sda_i) begin
              nxt_s.bst = BUS_IDLE;
            end else begin
              nxt_s.cnt = 4'h9;
            end
          end else if (fall_c && s_ff.cnt == 4'h9) begin
            load_rd = 1'b1;
          end
        end
        default: begin
          nxt_s.bst = BUS_IDLE;
        end
      endcase
    end

    // Read data goes out MSB first, released bit means one
    if (load_rd) begin
      nxt_s.bst = BUS_RDAT;
      nxt_s.shift = rd_byte;
      nxt_s.drive = ~rd_byte[7];
      nxt_s.cnt = 4'h1;
      status_rd = (s_ff.ptr == REG_STATUS);
    end

    if (wr_en) begin
      case (s_ff.ptr)
        REG_CONFIG: nxt_s.cfg = s_ff.shift;
        REG_RATE: nxt_s.rate = s_ff.shift;
        REG_LOC_HLIM: nxt_s.loc_hlim = s_ff.shift;
        REG_LOC_LLIM: nxt_s.loc_llim = s_ff.shift;
        REG_REM_HLIM_HI: nxt_s.rhl_hi = s_ff.shift;
        REG_REM_LLIM_HI: nxt_s.rll_hi = s_ff.shift;
        REG_OFS_HI: nxt_s.ofs_hi = s_ff.shift;
        REG_OFS_LO: nxt_s.ofs_lo = {s_ff.shift[7:5], 5'h00};
        REG_REM_HLIM_LO: nxt_s.rhl_lo = {s_ff.shift[7:5], 5'h00};
        REG_REM_LLIM_LO: nxt_s.rll_lo = {s_ff.shift[7:5], 5'h00};
        default: nxt_s.cfg = s_ff.cfg;
      endcase
    end

    // Read clears first, so a compare in the same cycle still sets
    if (status_rd) begin
      nxt_s.flags = 4'h0;
    end
    if (cv.cmp) begin
      nxt_s.flags = nxt_s.flags | {
        below({s_ff.loc_hlim, 3'h0}, loc_val),
        below(loc_val, {s_ff.loc_llim, 3'h0}),
        below({s_ff.rhl_hi, s_ff.rhl_lo[7:5]}, rem_val),
        below(rem_val, {s_ff.rll_hi, s_ff.rll_lo[7:5]})};
    end
    nxt_s.alert = (|s_ff.flags) & ~s_ff.cfg[CFG_MASK];
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_ff <= '{bst: BUS_IDLE, scl_q: 1'b1, sda_q: 1'b1, cnt: 4'h0, shift: 8'h00,
                rw: 1'b0, drive: 1'b0, ptr: 8'h00,
                loc: RST_TEMP, rem_hi: RST_TEMP, rem_lo: RST_LO_BITS,
                ofs_hi: RST_OFS, ofs_lo: RST_OFS,
                cfg: RST_CONFIG, rate: RST_RATE,
                loc_hlim: RST_HLIM, loc_llim: RST_LLIM, rhl_hi: RST_HLIM,
                rhl_lo: RST_LO_BITS, rll_hi: RST_LLIM, rll_lo: RST_LO_BITS,
                flags: 4'h0, alert: 1'b0, pin_lo: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sda_o = s_ff.pin_lo;
  assign sda_oe_n_o = ~s_ff.drive;
  assign alert_o = s_ff.pin_lo;
  assign alert_oe_n_o = ~s_ff.alert;
  assign adc_start_o = cv.adc_start;
  assign adc_remote_o = cv.adc_remote;

  //////////////////////////////////////////////////////////////////////////////
  property p_local_msb;
    @(posedge clk_i) disable iff (rst_i)
      adc_done_i && !cv.adc_remote |=> s_ff.loc == $past(adc_data_i[10:3]);
  endproperty
  a_local_msb: assert property (p_local_msb) else $error("local byte wrong");

  property p_offset_add;
    @(posedge clk_i) disable iff (rst_i)
      adc_done_i && cv.adc_remote |=> rem_val == $past(rem_sum);
  endproperty
  a_offset_add: assert property (p_offset_add) else $error("remote offset sum wrong");

  property p_low_bits_zero;
    @(posedge clk_i) disable iff (rst_i)
      s_ff.rem_lo[4:0] == 5'h00 && s_ff.ofs_lo[4:0] == 5'h00;
  endproperty
  a_low_bits_zero: assert property (p_low_bits_zero) else $error("low bits not zero");

  property p_alert_follows;
    @(posedge clk_i) disable iff (rst_i)
      (|s_ff.flags) && !s_ff.cfg[CFG_MASK] |=> !alert_oe_n_o;
  endproperty
  a_alert_follows: assert property (p_alert_follows) else $error("alert not driven");

  property p_low_flag_set;
    @(posedge clk_i) disable iff (rst_i)
      cv.cmp && below(rem_val, {s_ff.rll_hi, s_ff.rll_lo[7:5]}) |=> s_ff.flags[0];
  endproperty
  a_low_flag_set: assert property (p_low_flag_set) else $error("low flag missed");

  property p_status_clear;
    @(posedge clk_i) disable iff (rst_i)
      status_rd && !cv.cmp |=> s_ff.flags == 4'h0 ##1 alert_oe_n_o;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status read kept flags");

endmodule : tdm_core

/* bench/tdm_adc_model.sv */
// Converter front end model: answers each start with one done pulse after a delay.
// Assumes start is a one-cycle pulse and the channel select holds until done.
`timescale 1ns/100ps
module tdm_adc_model #(
  parameter int DELAY = 20
) (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic remote_i,
  input wire logic [10:0] loc_val_i,
  input wire logic [10:0] rem_val_i,
  output logic done_o,
  output logic [10:0] data_o
);
  int cnt = 0;

  initial begin
    done_o = 1'b0;
    data_o = 11'h5a5;
  end

  always @(posedge clk_i) begin
    done_o <= 1'b0;
    // Junk outside done, toggled so a stale sample cannot pass
    data_o <= ~data_o;
    if (start_i) begin
      cnt <= DELAY;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      done_o <= 1'b1;
      data_o <= remote_i ? rem_val_i : loc_val_i;
    end
  end
endmodule : tdm_adc_model

/* bench/test_dual_temp_monitor_core.sv */
// Self-checking bench of the temperature monitor core, driven as a bus host.
// Assumes the converter model in tdm_adc_model and a pulled-up data line.
`timescale 1ns/100ps
module test_dual_temp_monitor_core;
  import tdm_pkg::*;
  // Bus address is arbitrary
  localparam logic [6:0] ADDR = 7'h2a;
  localparam logic [10:0] LOC_VAL = 11'h0c8;
  localparam logic [10:0] REM_VAL = 11'h0cd;
  localparam logic [10:0] OFS = 11'h7ff;
  localparam logic [10:0] SUM = REM_VAL + OFS;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl = 1'b1;
  logic sda_h = 1'b1;
  logic standby_select_pin = 1'b0;
  logic sda_oe_n, sda_dev, alert_oe_n, alert_dev, done, start, remote;
  logic [10:0] data;
  wire logic sda_line = sda_h & (sda_oe_n | sda_dev);
  int n_mismatch = 0;
  int cmp_count = 0;

  tdm_core #(.SMB_ADDR(ADDR), .CONV_BASE_CYC(512)) i_tdm_core (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_dev),
    .sda_oe_n_o(sda_oe_n), .alert_o(alert_dev), .alert_oe_n_o(alert_oe_n),
    .standby_select_pin_i(standby_select_pin), .adc_done_i(done), .adc_data_i(data),
    .adc_start_o(start), .adc_remote_o(remote));

  tdm_adc_model i_tdm_adc_model (
    .clk_i(clk_i), .start_i(start), .remote_i(remote), .loc_val_i(LOC_VAL),
    .rem_val_i(REM_VAL), .done_o(done), .data_o(data));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Eight clocks a bit; line sampled late in the high phase
  task automatic sbit(input logic b, output logic s);
    sda_h <= b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    s = sda_line;
    scl <= 1'b0;
    tick(2);
  endtask : sbit

  task automatic sbyte(input logic [7:0] b, output logic [7:0] got);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sbit(b[i], s);
      got[i] = s;
    end
  endtask : sbyte

  // Also serves as repeated start
  task automatic start_c();
    sda_h <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(3);
    sda_h <= 1'b0;
    tick(3);
    scl <= 1'b0;
    tick(2);
  endtask : start_c

  task automatic stop_c();
    sda_h <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(3);
    sda_h <= 1'b1;
    tick(4);
  endtask : stop_c

  task automatic send(input logic [7:0] b);
    logic [7:0] g;
    logic a;
    sbyte(b, g);
    sbit(1'b1, a);
    chk("slave ack", 8'h00, {7'h00, a});
  endtask : send

  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d);
    start_c();
    send({ADDR, 1'b0});
    send(ptr);
    send(d);
    stop_c();
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    start_c();
    send({ADDR, 1'b0});
    send(ptr);
    start_c();
    send({ADDR, 1'b1});
    sbyte(8'hff, d);
    // Master NACK ends the read
    sbit(1'b1, a);
    stop_c();
  endtask : reg_rd

  task automatic rd_chk(input string what, input logic [7:0] ptr, input logic [7:0] mask,
                        input logic [7:0] exp);
    logic [7:0] d;
    reg_rd(ptr, d);
    chk(what, exp, d & mask);
  endtask : rd_chk

  // Sampled at the falling edge, clear of the registered updates
  task automatic wait_alert(input logic exp, input int lim);
    int k;
    k = 0;
    @(negedge clk_i);
    while (alert_oe_n !== exp && k < lim) begin
      @(negedge clk_i);
      k++;
    end
    // Judged at the falling edge, before the next registered update
    chk("alert pin", {7'h00, exp}, {7'h00, alert_oe_n});
    chk("alert level", 8'h00, {7'h00, alert_dev});
    if (alert_oe_n !== exp) begin
      stop_test();
    end
    tick(1);
  endtask : wait_alert

  task automatic count_starts(input int lim, output int n);
    n = 0;
    repeat (lim) begin
      @(negedge clk_i);
      if (start === 1'b1) begin
        n++;
      end
    end
    tick(1);
  endtask : count_starts

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    int n;
    tick(2);
    rst_i <= 1'b0;
    tick(2);
    wait_alert(1'b0, 40);
    rd_chk("local temp", REG_LOC_TEMP, 8'hff, RST_TEMP);
    rd_chk("remote high", REG_REM_HI, 8'hff, RST_TEMP);
    rd_chk("remote low", REG_REM_LO, 8'hff, 8'h00);
    rd_chk("offset high", REG_OFS_HI, 8'hff, 8'h00);
    rd_chk("offset low", REG_OFS_LO, 8'hff, 8'h00);
    rd_chk("status", REG_STATUS, 8'h78, 8'h28);
    count_starts(300, n);
    chk("standby starts", 8'h00, n[7:0]);
    reg_wr(REG_LOC_LLIM, 8'h80);
    reg_wr(REG_REM_LLIM_HI, 8'h80);
    reg_rd(REG_STATUS, d);
    wait_alert(1'b1, 20);
    tick(300);
    rd_chk("status", REG_STATUS, 8'h78, 8'h00);
    // Leave standby; values must land before the flags are judged
    standby_select_pin <= 1'b1;
    count_starts(400, n);
    chk("converter runs", 8'h01, {7'h00, n >= 2});
    rd_chk("local temp", REG_LOC_TEMP, 8'hff, LOC_VAL[10:3]);
    rd_chk("remote high", REG_REM_HI, 8'hff, REM_VAL[10:3]);
    rd_chk("remote low", REG_REM_LO, 8'hff, {REM_VAL[2:0], 5'h00});
    rd_chk("status", REG_STATUS, 8'h78, 8'h00);
    wait_alert(1'b1, 2);
    reg_wr(REG_OFS_HI, OFS[10:3]);
    reg_wr(REG_OFS_LO, {OFS[2:0], 5'h00});
    rd_chk("offset high", REG_OFS_HI, 8'hff, OFS[10:3]);
    rd_chk("offset low", REG_OFS_LO, 8'hff, {OFS[2:0], 5'h00});
    // Read-only place must ignore the write
    reg_wr(REG_REM_HI, 8'h00);
    rd_chk("remote high", REG_REM_HI, 8'hff, SUM[10:3]);
    rd_chk("remote low", REG_REM_LO, 8'hff, {SUM[2:0], 5'h00});
    reg_wr(REG_LOC_HLIM, LOC_VAL[10:3] - 8'h01);
    reg_wr(REG_REM_HLIM_HI, SUM[10:3]);
    reg_wr(REG_REM_HLIM_LO, {SUM[2:0] - 3'h1, 5'h00});
    wait_alert(1'b0, 300);
    rd_chk("status", REG_STATUS, 8'h78, 8'h50);
    reg_wr(REG_CONFIG, 8'h80);
    wait_alert(1'b1, 300);
    reg_wr(REG_CONFIG, 8'h00);
    wait_alert(1'b0, 300);
    reg_wr(REG_LOC_HLIM, 8'h7f);
    reg_wr(REG_REM_HLIM_HI, 8'h7f);
    reg_rd(REG_STATUS, d);
    tick(300);
    rd_chk("status", REG_STATUS, 8'h78, 8'h00);
    wait_alert(1'b1, 2);
    reg_wr(REG_RATE, 8'h07);
    rd_chk("rate", REG_RATE, 8'hff, 8'h07);
    rd_chk("unmapped", 8'h20, 8'hff, 8'h00);
    // Register standby; let the conversion in flight finish first (a local one in flight is not followed by its remote)
    reg_wr(REG_CONFIG, 8'h40);
    tick(60);
    count_starts(200, n);
    chk("config standby starts", 8'h00, n[7:0]);
    stop_test();
  end
endmodule : test_dual_temp_monitor_core
